// ===== flash_params.svh
// Constants of the flash command sequencer: command codes, status bit
// positions, identity addresses and sequencer counts.
// Assumes a 20-bit byte address and sixteen 64 KB sectors.
`ifndef FLASH_PARAMS_SVH
`define FLASH_PARAMS_SVH

// Command codes
`define CMD_READ_ARRAY 8'hff
`define CMD_ERASE_SETUP 8'h20
`define CMD_CONFIRM 8'hd0
`define CMD_PROG_SETUP_A 8'h40
`define CMD_PROG_SETUP_B 8'h10
`define CMD_SUSPEND 8'hb0
`define CMD_READ_STATUS 8'h70
`define CMD_CLEAR_STATUS 8'h50
`define CMD_IDENT 8'h90

// Identity read addresses
`define ID_ADDR_MAKER 20'h00000
`define ID_ADDR_PART 20'h00001
`define ID_OTHER_DATA 8'h00

// Status bit positions
`define ST_READY 7
`define ST_ESUSP 6
`define ST_ERASE_ERR 5
`define ST_PROG_ERR 4
`define ST_PSUSP 2
`define ST_PROTECT 1

// Array geometry
`define ADDR_W 20
`define SECTOR_W 4
`define OFS_W 16
`define ARRAY_LAST 20'hfffff
`define SECTOR_LAST_OFS 16'hffff
`define TOP_SECTOR 4'hf
`define ERASED_BYTE 8'hff

// Lock bits come up set
`define LOCK_RESET 16'hffff

// Program pulses per byte
`define PROG_PULSE_LAST 4'h7

`endif

// ===== flash_pkg.sv
// Types of the flash command sequencer: sequencer states, read modes
// and pending second-cycle commands.
// Assumes flash_params.svh is available on the include path.
package flash_pkg;

	typedef enum logic [5:0] {
		SQ_READY = 6'h01,
		SQ_PROG = 6'h02,
		SQ_VERIFY = 6'h04,
		SQ_ERASE = 6'h08,
		SQ_ESUSP = 6'h10,
		SQ_PSUSP = 6'h20
	} seq_state_type;

	typedef enum logic [2:0] {
		RM_ARRAY = 3'h1,
		RM_STATUS = 3'h2,
		RM_IDENT = 3'h4
	} read_mode_type;

	typedef enum logic [2:0] {
		PD_NONE = 3'h1,
		PD_ERASE = 3'h2,
		PD_PROG = 3'h4
	} pend_type;

endpackage : flash_pkg

// ===== sector_lock.sv
// Per-sector write-lock bits combined with the two protect pins.
// Assumes a synchronous active-low reset from the parent.
`timescale 1ns/10ps
`include "flash_params.svh"
module sector_lock (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic lock_wr_i,
	input wire logic [3:0] lock_sector_i,
	input wire logic lock_set_i,
	input wire logic [3:0] check_sector_i,
	input wire logic top_sector_protect_n_i,
	input wire logic write_protect_n_i,
	output logic locked_o
);
	logic [15:0] wlock_q;

	// (RULE_23) locks set at reset
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			wlock_q <= `LOCK_RESET;
		end else if (lock_wr_i) begin
			wlock_q[lock_sector_i] <= lock_set_i;
		end
	end

	// (RULE_24) pins override lock bits
	always_comb begin
		if (check_sector_i == `TOP_SECTOR) begin
			locked_o = wlock_q[check_sector_i] | ~top_sector_protect_n_i;
		end else begin
			locked_o = wlock_q[check_sector_i] | ~write_protect_n_i;
		end
	end

endmodule : sector_lock

// ===== flash_array.sv
// Byte array of the flash with program, erase and one read port.
// Assumes only one of program or erase is requested per cycle.
`timescale 1ns/10ps
`include "flash_params.svh"
module flash_array (
	input wire logic clk_i,
	input wire logic prog_we_i,
	input wire logic erase_we_i,
	input wire logic [19:0] waddr_i,
	input wire logic [7:0] wdata_i,
	input wire logic [19:0] raddr_i,
	output logic [7:0] rdata_o
);
	logic [7:0] mem [0:`ARRAY_LAST];

	// (RULE_06) program clears, erase sets
	always_ff @(posedge clk_i) begin
		if (prog_we_i) begin
			mem[waddr_i] <= mem[waddr_i] & wdata_i;
		end else if (erase_we_i) begin
			mem[waddr_i] <= `ERASED_BYTE;
		end
		rdata_o <= mem[raddr_i];
	end

endmodule : flash_array

// ===== flash_command_sequencer.sv
// Command front end and operation sequencer of a sector-erasable flash.
// Assumes one-cycle write and read strobes synchronous to clk_i.
//
// Overview of operation
// (RULE_01) Reset and the read-array code put reads into array mode.
// (RULE_02) Read-array is ignored while erase or program runs unsuspended.
// (RULE_03) Sector erase is setup then confirm, any address in the sector.
// (RULE_04) Either program setup code starts a byte program.
// (RULE_05) Second write gives address and data; pulses run automatically.
// (RULE_06) Program only clears bits; erase sets the whole sector to one.
// (RULE_07) Locked or pin-protected targets stay unchanged; cause is reported.
// (RULE_08) After a program command reads return status.
// (RULE_09) Verify errors only on bits left one that should be zero.
// (RULE_10) Erase suspend halts at a byte boundary and flags suspension.
// (RULE_11) Erase suspended accepts read array, program, status, resume.
// (RULE_12) Erase resume waits for a program run inside the suspension.
// (RULE_13) Program suspend halts programming; reads keep returning status; here a read-array command during the suspension switches reads to the array.
// (RULE_14) Host holds reset and init inactive during any suspension.
// (RULE_15) Read-status code makes every later read return status; here a later read-array or identity command ends it.
// (RULE_16) Only the sequencer sets errors; only clear-status clears them.
// (RULE_17) Identity mode returns maker and part codes at addresses 0, 1.
// (RULE_18) Status bit 7 is ready; lower bits are invalid while busy.
// (RULE_19) Bit 6 shows erase suspended, bit 2 program suspended.
// (RULE_20) Bit 5 erase error, bit 4 program error; both is a bad sequence.
// (RULE_21) Bit 1 protection abort, taken only when an operation starts.
// (RULE_22) Host masks bit 0 and clears status after a program error.
// (RULE_23) All write-lock bits are set at power-up.
// (RULE_24) Protect pins override lock bits for top or other sectors.
// (RULE_25) Non-confirm after erase setup aborts with both error flags.
`timescale 1ns/10ps
`include "flash_params.svh"
module flash_command_sequencer
	import flash_pkg::*;
#(
	parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary value
	parameter logic [7:0] PART_CODE = 8'ha5 // Arbitrary value
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic init_n_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [19:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic top_sector_protect_n_i,
	input wire logic write_protect_n_i,
	input wire logic lock_wr_i,
	input wire logic [3:0] lock_sector_i,
	input wire logic lock_set_i,
	output logic [7:0] rdata_o,
	output logic rdata_valid_o,
	output logic [7:0] status_o
);
	seq_state_type seq_q;
	read_mode_type rm_q;
	read_mode_type rm_p1_q;
	pend_type pend_q;
	logic srst;
	logic srst_n;
	logic locked;
	logic [7:0] mem_rdata;
	logic [19:0] prog_addr_q;
	logic [7:0] prog_data_q;
	logic [3:0] erase_sector_q;
	logic [15:0] erase_ofs_q;
	logic [3:0] pcnt_q;
	logic vcnt_q;
	logic erase_held_q;
	logic resume_req_q;
	logic err_erase_q;
	logic err_prog_q;
	logic err_prot_q;
	logic rd_p1_q;
	logic [19:0] raddr_p1_q;
	logic [7:0] status_now;
	logic is_ready;
	logic is_busy;
	logic wr_idle;
	logic w_ff;
	logic w_erase;
	logic w_conf;
	logic w_prog;
	logic w_susp;
	logic w_stat;
	logic w_clr;
	logic w_id;
	logic same_sector;
	logic prog_ok;
	logic prog_lockfail;
	logic prog_same;
	logic erase_ok;
	logic erase_lockfail;
	logic erase_bad;
	logic suspend_cmd;
	logic resume_cmd;
	logic erase_done;
	logic prog_last;
	logic prog_we;
	logic verify_fail;
	logic [19:0] waddr;
	logic [19:0] raddr;

	// Either reset input restarts the block
	assign srst = ~rst_n_i | ~init_n_i;
	assign srst_n = ~srst;

	// Sequencer condition decode
	assign is_ready = (seq_q == SQ_READY);
	assign is_busy = (seq_q == SQ_PROG) | (seq_q == SQ_VERIFY) |
		(seq_q == SQ_ERASE);
	assign wr_idle = wr_i & (pend_q == PD_NONE);
	assign w_ff = (wdata_i == `CMD_READ_ARRAY);
	assign w_erase = (wdata_i == `CMD_ERASE_SETUP);
	assign w_conf = (wdata_i == `CMD_CONFIRM);
	assign w_prog = (wdata_i == `CMD_PROG_SETUP_A) |
		(wdata_i == `CMD_PROG_SETUP_B);
	assign w_susp = (wdata_i == `CMD_SUSPEND);
	assign w_stat = (wdata_i == `CMD_READ_STATUS);
	assign w_clr = (wdata_i == `CMD_CLEAR_STATUS);
	assign w_id = (wdata_i == `CMD_IDENT);
	assign same_sector = (addr_i[19:16] == erase_sector_q);

	// (RULE_07) protection checked when the operation starts
	assign prog_lockfail = wr_i & (pend_q == PD_PROG) & locked;
	assign erase_lockfail = wr_i & (pend_q == PD_ERASE) & w_conf & locked;
	// (RULE_11) no program into the suspended sector
	assign prog_same = wr_i & (pend_q == PD_PROG) & ~locked &
		erase_held_q & same_sector;
	assign prog_ok = wr_i & (pend_q == PD_PROG) & ~locked &
		~(erase_held_q & same_sector);
	// (RULE_03) confirm at any address starts erase of the sector it addresses
	assign erase_ok = wr_i & (pend_q == PD_ERASE) & w_conf & ~locked;
	// (RULE_25) wrong second cycle aborts erase
	assign erase_bad = wr_i & (pend_q == PD_ERASE) & ~w_conf;
	assign suspend_cmd = wr_idle & w_susp &
		((seq_q == SQ_ERASE) | (seq_q == SQ_PROG));
	assign resume_cmd = wr_idle & w_conf &
		((seq_q == SQ_ESUSP) | (seq_q == SQ_PSUSP));
	assign erase_done = (seq_q == SQ_ERASE) &
		(erase_ofs_q == `SECTOR_LAST_OFS);
	assign prog_last = (seq_q == SQ_PROG) & (pcnt_q == `PROG_PULSE_LAST);
	assign prog_we = prog_last & ~suspend_cmd;
	// (RULE_09) only ones left unprogrammed count
	assign verify_fail = (seq_q == SQ_VERIFY) & vcnt_q &
		(|(mem_rdata & ~prog_data_q));

	// Array port steering
	assign waddr = (seq_q == SQ_ERASE) ? {erase_sector_q, erase_ofs_q} :
		prog_addr_q;
	assign raddr = (seq_q == SQ_VERIFY) ? prog_addr_q : addr_i;

	// (RULE_18) status word assembled from live state
	always_comb begin
		status_now = 8'h00;
		status_now[`ST_READY] = ~is_busy;
		status_now[`ST_ESUSP] = erase_held_q;
		status_now[`ST_ERASE_ERR] = err_erase_q;
		status_now[`ST_PROG_ERR] = err_prog_q;
		status_now[`ST_PSUSP] = (seq_q == SQ_PSUSP);
		status_now[`ST_PROTECT] = err_prot_q;
	end

	sector_lock u_lock (
		.clk_i(clk_i),
		.rst_n_i(srst_n),
		.lock_wr_i(lock_wr_i),
		.lock_sector_i(lock_sector_i),
		.lock_set_i(lock_set_i),
		.check_sector_i(addr_i[19:16]),
		.top_sector_protect_n_i(top_sector_protect_n_i),
		.write_protect_n_i(write_protect_n_i),
		.locked_o(locked)
	);

	flash_array u_array (
		.clk_i(clk_i),
		.prog_we_i(prog_we),
		.erase_we_i(seq_q == SQ_ERASE),
		.waddr_i(waddr),
		.wdata_i(prog_data_q),
		.raddr_i(raddr),
		.rdata_o(mem_rdata)
	);

	// Pending second write cycle
	always_ff @(posedge clk_i) begin
		if (srst) begin
			pend_q <= PD_NONE;
		end else if (wr_i && pend_q != PD_NONE) begin
			pend_q <= PD_NONE;
		end else if (wr_idle && w_erase && is_ready) begin
			pend_q <= PD_ERASE;
		end else if (wr_idle && w_prog && (is_ready ||
			seq_q == SQ_ESUSP)) begin
			// (RULE_04) either setup code accepted
			pend_q <= PD_PROG;
		end
	end

	// Read mode selected by commands
	always_ff @(posedge clk_i) begin
		if (srst) begin
			// (RULE_01) array mode after reset
			rm_q <= RM_ARRAY;
		end else if (wr_idle) begin
			if (w_ff && !is_busy) begin
				// (RULE_02) read array refused while busy
				rm_q <= RM_ARRAY;
			end else if (w_stat) begin
				// (RULE_15) status until a read-array or identity command
				rm_q <= RM_STATUS;
			end else if (w_id && is_ready) begin
				// (RULE_17) enter identity mode
				rm_q <= RM_IDENT;
			end else if (w_clr && is_ready && rm_q == RM_IDENT) begin
				rm_q <= RM_ARRAY;
			end else if ((w_erase && is_ready) || suspend_cmd ||
				resume_cmd || (w_prog && (is_ready ||
				seq_q == SQ_ESUSP))) begin
				// (RULE_08) status once a program is written
				rm_q <= RM_STATUS;
			end
		end
	end

	// Operation sequencer
	always_ff @(posedge clk_i) begin
		if (srst) begin
			seq_q <= SQ_READY;
		end else begin
			case (seq_q)
				SQ_READY: begin
					if (prog_ok) begin
						seq_q <= SQ_PROG;
					end else if (erase_ok) begin
						seq_q <= SQ_ERASE;
					end
				end
				SQ_PROG: begin
					if (suspend_cmd) begin
						// (RULE_13) halt between pulses
						seq_q <= SQ_PSUSP;
					end else if (prog_last) begin
						seq_q <= SQ_VERIFY;
					end
				end
				SQ_VERIFY: begin
					if (vcnt_q) begin
						// (RULE_12) resume only after program ends
						if (erase_held_q && resume_req_q) begin
							seq_q <= SQ_ERASE;
						end else if (erase_held_q) begin
							seq_q <= SQ_ESUSP;
						end else begin
							seq_q <= SQ_READY;
						end
					end
				end
				SQ_ERASE: begin
					if (erase_done) begin
						seq_q <= SQ_READY;
					end else if (suspend_cmd) begin
						// (RULE_10) halt after current byte
						seq_q <= SQ_ESUSP;
					end
				end
				SQ_ESUSP: begin
					// (RULE_11) program elsewhere or resume
					if (prog_ok) begin
						seq_q <= SQ_PROG;
					end else if (resume_cmd) begin
						seq_q <= SQ_ERASE;
					end
				end
				SQ_PSUSP: begin
					if (resume_cmd) begin
						seq_q <= SQ_PROG;
					end
				end
				default: begin
					seq_q <= SQ_READY;
				end
			endcase
		end
	end

	// Suspended erase and resume request bookkeeping
	always_ff @(posedge clk_i) begin
		if (srst) begin
			erase_held_q <= 1'b0;
			resume_req_q <= 1'b0;
		end else begin
			// (RULE_19) erase suspended flag
			if (seq_q == SQ_ERASE && suspend_cmd && !erase_done) begin
				erase_held_q <= 1'b1;
			end else if ((seq_q == SQ_ESUSP && resume_cmd) ||
				(seq_q == SQ_VERIFY && vcnt_q && resume_req_q)) begin
				erase_held_q <= 1'b0;
			end
			// (RULE_12) remember resume given during program
			if (wr_idle && w_conf && erase_held_q && (seq_q == SQ_PROG ||
				seq_q == SQ_VERIFY)) begin
				resume_req_q <= 1'b1;
			end else if (!erase_held_q) begin
				resume_req_q <= 1'b0;
			end
		end
	end

	// Operation targets and counters
	always_ff @(posedge clk_i) begin
		if (srst) begin
			prog_addr_q <= 20'h00000;
			prog_data_q <= 8'h00;
			erase_sector_q <= 4'h0;
			erase_ofs_q <= 16'h0000;
			pcnt_q <= 4'h0;
			vcnt_q <= 1'b0;
		end else begin
			if (prog_ok) begin
				// (RULE_05) capture address and data
				prog_addr_q <= addr_i;
				prog_data_q <= wdata_i;
				pcnt_q <= 4'h0;
			end else if (seq_q == SQ_PROG && !suspend_cmd &&
				!prog_last) begin
				pcnt_q <= pcnt_q + 4'h1;
			end
			if (erase_ok) begin
				erase_sector_q <= addr_i[19:16];
				erase_ofs_q <= 16'h0000;
			end else if (seq_q == SQ_ERASE) begin
				erase_ofs_q <= erase_ofs_q + 16'h0001;
			end
			vcnt_q <= (seq_q == SQ_VERIFY) & ~vcnt_q;
		end
	end

	// (RULE_16) error flags, set wins over clear
	always_ff @(posedge clk_i) begin
		if (srst) begin
			err_erase_q <= 1'b0;
			err_prog_q <= 1'b0;
			err_prot_q <= 1'b0;
		end else begin
			// (RULE_20) erase error and bad sequence
			err_erase_q <= (err_erase_q & ~(wr_idle & w_clr & is_ready)) |
				erase_lockfail | erase_bad;
			err_prog_q <= (err_prog_q & ~(wr_idle & w_clr & is_ready)) |
				prog_lockfail | prog_same | erase_bad | verify_fail;
			// (RULE_21) protect abort sampled at start
			err_prot_q <= (err_prot_q & ~(wr_idle & w_clr & is_ready)) |
				prog_lockfail | erase_lockfail;
		end
	end

	// Read pipeline and outputs
	always_ff @(posedge clk_i) begin
		if (srst) begin
			rd_p1_q <= 1'b0;
			raddr_p1_q <= 20'h00000;
			rm_p1_q <= RM_ARRAY;
			rdata_o <= 8'h00;
			rdata_valid_o <= 1'b0;
			status_o <= 8'h00;
		end else begin
			rd_p1_q <= rd_i;
			raddr_p1_q <= addr_i;
			rm_p1_q <= rm_q;
			rdata_valid_o <= rd_p1_q;
			status_o <= status_now;
			case (rm_p1_q)
				RM_ARRAY: rdata_o <= mem_rdata;
				RM_STATUS: rdata_o <= status_now;
				RM_IDENT: begin
					if (raddr_p1_q == `ID_ADDR_MAKER) begin
						rdata_o <= MAKER_CODE;
					end else if (raddr_p1_q == `ID_ADDR_PART) begin
						rdata_o <= PART_CODE;
					end else begin
						rdata_o <= `ID_OTHER_DATA;
					end
				end
				default: rdata_o <= 8'h00;
			endcase
		end
	end

	// Checks next to the logic
	a_reset_array_mode: assert property (@(posedge clk_i) // RULE_01
		srst |=> rm_q == RM_ARRAY && seq_q == SQ_READY)
		else $error("not in array mode after reset");
	a_busy_ignores_ff: assert property (@(posedge clk_i) // RULE_02
		disable iff (srst) wr_idle && w_ff && is_busy |=> rm_q != RM_ARRAY)
		else $error("read array taken while busy");
	a_erase_start: assert property (@(posedge clk_i) // RULE_03
		disable iff (srst) erase_ok |=> seq_q == SQ_ERASE &&
		erase_sector_q == $past(addr_i[19:16]))
		else $error("erase did not start on confirm");
	a_prog_capture: assert property (@(posedge clk_i) // RULE_05
		disable iff (srst) prog_ok |=> seq_q == SQ_PROG &&
		prog_data_q == $past(wdata_i) && prog_addr_q == $past(addr_i))
		else $error("program capture wrong");
	// A suspend inside the pulse train legally stretches it
	a_prog_pulses: assert property (@(posedge clk_i) // RULE_05
		disable iff (srst) prog_ok ##1 !suspend_cmd [*8]
		|=> seq_q == SQ_VERIFY)
		else $error("program pulse count wrong");
	a_locked_refused: assert property (@(posedge clk_i) // RULE_07
		disable iff (srst) (prog_lockfail || erase_lockfail) && is_ready
		|=> seq_q == SQ_READY ##1 status_o[`ST_PROTECT])
		else $error("locked operation not refused");
	a_status_on_prog: assert property (@(posedge clk_i) // RULE_08
		disable iff (srst) seq_q == SQ_PROG |-> rm_q == RM_STATUS)
		else $error("program running outside status mode");
	a_suspend_halts: assert property (@(posedge clk_i) // RULE_10
		disable iff (srst) suspend_cmd && seq_q == SQ_ERASE && !erase_done
		|=> seq_q == SQ_ESUSP ##1 status_o[`ST_ESUSP])
		else $error("erase suspend not taken");
	a_resume_waits: assert property (@(posedge clk_i) // RULE_12
		disable iff (srst) seq_q == SQ_PROG && erase_held_q
		|=> seq_q != SQ_ERASE)
		else $error("erase resumed before program end");
	a_clear_status: assert property (@(posedge clk_i) // RULE_16
		disable iff (srst) wr_idle && w_clr && is_ready
		|=> !err_erase_q && !err_prog_q && !err_prot_q)
		else $error("clear status did not clear flags");
	a_ident_maker: assert property (@(posedge clk_i) // RULE_17
		disable iff (srst) rm_q == RM_IDENT && rd_i &&
		addr_i == `ID_ADDR_MAKER |=> ##1 rdata_o == MAKER_CODE)
		else $error("maker code not returned");
	a_ready_bit: assert property (@(posedge clk_i) // RULE_18
		disable iff (srst) $past(seq_q == SQ_ERASE) && !srst
		|-> !status_o[`ST_READY])
		else $error("ready shown while erasing");
	a_bad_sequence: assert property (@(posedge clk_i) // RULE_25
		disable iff (srst) erase_bad |=> err_erase_q && err_prog_q &&
		seq_q == SQ_READY)
		else $error("bad erase sequence not flagged");

endmodule : flash_command_sequencer

// ===== host_model.sv
// Host chipset model: issues command writes and reads to the sequencer.
// Assumes one-cycle strobes sampled on the rising edge of clk_i.
`timescale 1ns/10ps
module host_model (
	input wire logic clk_i,
	input wire logic [7:0] rdata_i,
	input wire logic rdata_valid_i,
	output logic wr_o,
	output logic rd_o,
	output logic [19:0] addr_o,
	output logic [7:0] wdata_o
);
	// Bus idles with strobes low
	initial begin
		wr_o = 1'h0;
		rd_o = 1'h0;
		addr_o = 20'h00000;
		wdata_o = 8'h00;
	end

	// One write cycle; released lines show the inverse of the last value
	// caller addresses both cycles
	task automatic write_cmd(input logic [19:0] a, input logic [7:0] d);
		@(posedge clk_i);
		#1;
		wr_o = 1'h1;
		addr_o = a;
		wdata_o = d;
		@(posedge clk_i);
		#1;
		wr_o = 1'h0;
		addr_o = ~a;
		wdata_o = ~d;
	endtask : write_cmd

	// One read cycle; the answer stands one edge after the strobe is taken
	// reserved bit 0 masked
	task automatic read_cmd(input logic [19:0] a, output logic [7:0] d,
		output logic v);
		@(posedge clk_i);
		#1;
		rd_o = 1'h1;
		addr_o = a;
		@(posedge clk_i);
		#1;
		rd_o = 1'h0;
		addr_o = ~a;
		@(posedge clk_i);
		#1;
		d = rdata_i & 8'hfe;
		v = rdata_valid_i;
	endtask : read_cmd
endmodule : host_model

// ===== tb.sv
// Self-checking bench of the flash command sequencer.
// Assumes host_model drives the command and read strobes.
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
	$display("Error at %0t: got %h expected %h", $time, g, e); end end
module tb;
	logic clk_i, rst_n_i, init_n_i, wr_i, rd_i, tsp_n, wp_n;
	logic lock_wr_i, lock_set_i, rdata_valid_o;
	logic [19:0] addr_i;
	logic [7:0] wdata_i, rdata_o, status_o;
	logic [3:0] lock_sector_i;
	int miscompares = 0;
	int cmp_count = 0;
	int cycles = 0;

	flash_command_sequencer DUT (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.init_n_i(init_n_i), .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .top_sector_protect_n_i(tsp_n),
		.write_protect_n_i(wp_n), .lock_wr_i(lock_wr_i),
		.lock_sector_i(lock_sector_i), .lock_set_i(lock_set_i),
		.rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o),
		.status_o(status_o));
	host_model host (.clk_i(clk_i), .rdata_i(rdata_o),
		.rdata_valid_i(rdata_valid_o), .wr_o(wr_i), .rd_o(rd_i),
		.addr_o(addr_i), .wdata_o(wdata_i));

	// Clock at 50 MHz
	initial begin
		clk_i = 1'h0;
		forever #10 clk_i = ~clk_i;
	end

	// Hang guard
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 80000) begin
			miscompares++;
			$display("Error at %0t: timeout", $time);
			complete_run();
		end
	end

	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : complete_run

	// Read at an address and compare the masked byte
	task automatic rd_chk(input logic [19:0] a, input logic [7:0] e);
		logic [7:0] d;
		logic v;
		host.read_cmd(a, d, v);
		`CHK(v, 1'h1)
		`CHK(d, e & 8'hfe)
	endtask : rd_chk

	// Wait for ready; lower status bits mean nothing before that
	// host polls bit 7
	task automatic wait_ready();
		int n;
		n = 0;
		repeat (3) @(posedge clk_i);
		#1;
		while (status_o[7] !== 1'h1 && n < 70000) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		`CHK(status_o[7], 1'h1)
	endtask : wait_ready

	task automatic unlock(input logic [3:0] s);
		@(posedge clk_i);
		#1;
		lock_wr_i = 1'h1;
		lock_sector_i = s;
		lock_set_i = 1'h0;
		@(posedge clk_i);
		#1;
		lock_wr_i = 1'h0;
	endtask : unlock

	task automatic prog(input logic [19:0] a, input logic [7:0] c,
		input logic [7:0] d);
		host.write_cmd(a, c);
		host.write_cmd(a, d);
	endtask : prog

	task automatic t_reset_modes();
		`CHK(status_o, 8'h80)
		host.write_cmd(20'h00000, 8'h70);
		rd_chk(20'h12345, 8'h80);
		host.write_cmd(20'h00000, 8'h90);
		rd_chk(20'h00000, 8'h5a);
		rd_chk(20'h00001, 8'ha5);
		rd_chk(20'h00002, 8'h00);
		host.write_cmd(20'h00000, 8'h70);
		rd_chk(20'h00000, 8'h80);
		$display("test reset_modes done");
	endtask : t_reset_modes

	task automatic t_locked();
		prog(20'h20010, 8'h40, 8'h00);
		wait_ready();
		rd_chk(20'h20010, 8'h92);
		host.write_cmd(20'h00000, 8'h50);
		rd_chk(20'h00000, 8'h80);
		unlock(4'h1);
		host.write_cmd(20'h10000, 8'h20);
		host.write_cmd(20'h10000, 8'h70);
		wait_ready();
		rd_chk(20'h00000, 8'hb0);
		host.write_cmd(20'h00000, 8'h50);
		$display("test locked done");
	endtask : t_locked

	task automatic t_erase();
		logic [7:0] d;
		logic v;
		host.write_cmd(20'h10000, 8'h20);
		host.write_cmd(20'h1ffff, 8'hd0);
		repeat (20) @(posedge clk_i);
		host.write_cmd(20'h00000, 8'hff);
		host.read_cmd(20'h10000, d, v);
		`CHK(d[7], 1'h0)
		host.write_cmd(20'h00000, 8'hb0);
		wait_ready();
		rd_chk(20'h00000, 8'hc0);
		prog(20'h10020, 8'h40, 8'h00);
		wait_ready();
		rd_chk(20'h00000, 8'hd0);
		// Program another sector, then resume while it still runs
		unlock(4'h3);
		prog(20'h30000, 8'h40, 8'h00);
		host.write_cmd(20'h00000, 8'hd0);
		wait_ready();
		rd_chk(20'h00000, 8'h90);
		host.write_cmd(20'h00000, 8'h50);
		host.write_cmd(20'h00000, 8'hff);
		rd_chk(20'h10020, 8'hff);
		rd_chk(20'h1ffff, 8'hff);
		rd_chk(20'h30000, 8'h00);
		$display("test erase done");
	endtask : t_erase

	task automatic t_program();
		prog(20'h10005, 8'h40, 8'ha5);
		wait_ready();
		rd_chk(20'h10005, 8'h80);
		host.write_cmd(20'h00000, 8'hff);
		rd_chk(20'h10005, 8'ha5);
		prog(20'h10005, 8'h10, 8'hff);
		wait_ready();
		rd_chk(20'h00000, 8'h80);
		prog(20'h10005, 8'h40, 8'h0f);
		wait_ready();
		host.write_cmd(20'h00000, 8'hff);
		rd_chk(20'h10005, 8'h05);
		prog(20'h10006, 8'h40, 8'h3c);
		host.write_cmd(20'h00000, 8'hb0);
		wait_ready();
		rd_chk(20'h00000, 8'h84);
		host.write_cmd(20'h00000, 8'hff);
		rd_chk(20'h10005, 8'h05);
		host.write_cmd(20'h00000, 8'hd0);
		wait_ready();
		rd_chk(20'h00000, 8'h80);
		host.write_cmd(20'h00000, 8'hff);
		rd_chk(20'h10006, 8'h3c);
		$display("test program done");
	endtask : t_program

	task automatic t_pins();
		unlock(4'hf);
		tsp_n = 1'h0;
		prog(20'hf0000, 8'h40, 8'h00);
		wait_ready();
		rd_chk(20'h00000, 8'h92);
		host.write_cmd(20'h00000, 8'h50);
		tsp_n = 1'h1;
		wp_n = 1'h0;
		prog(20'h10007, 8'h40, 8'h00);
		wait_ready();
		rd_chk(20'h00000, 8'h92);
		host.write_cmd(20'h00000, 8'h50);
		wp_n = 1'h1;
		// reset only with no operation suspended
		rst_n_i = 1'h0;
		repeat (2) @(posedge clk_i);
		#1;
		rst_n_i = 1'h1;
		rd_chk(20'h10005, 8'h05);
		prog(20'h10008, 8'h40, 8'h00);
		wait_ready();
		rd_chk(20'h00000, 8'h92);
		// Init input restarts the block like reset
		init_n_i = 1'h0;
		repeat (2) @(posedge clk_i);
		#1;
		init_n_i = 1'h1;
		rd_chk(20'h10005, 8'h05);
		$display("test pins done");
	endtask : t_pins

	// Main sequence
	initial begin
		rst_n_i = 1'h0;
		init_n_i = 1'h1;
		tsp_n = 1'h1;
		wp_n = 1'h1;
		lock_wr_i = 1'h0;
		lock_sector_i = 4'h0;
		lock_set_i = 1'h1;
		repeat (2) @(posedge clk_i);
		#1;
		rst_n_i = 1'h1;
		repeat (2) @(posedge clk_i);
		#1;
		t_reset_modes();
		t_locked();
		t_erase();
		t_program();
		t_pins();
		complete_run();
	end
endmodule : tb
